// >>> shared/eeprom_pkg.sv
// Overview of operation
// - data line changes only while clock low; changes during clock high mark start/stop
// - falling data line with clock high is a start and opens every transfer
// - rising data line with clock high is a stop; read sequences then go standby
// - words are 8 bits; device pulls data low on the ninth clock as acknowledge
// - standby after reset, and after stop once internal work is done
// - address word follows start; top four bits 1010 select the main array
// - address bits 3..1 must equal select pins; mismatch returns to standby, no ack
// - address bit 0 picks direction: one reads, zero writes
// - top four bits 1011 select the serial-number block, same pin compare
// - serial-number block contents are never changed by any write
// - byte write: address, word address, one data byte, each acked, then stop
// - stop after write starts a timed cycle of at most 5 ms, no response meanwhile
// - write cycle time runs from the stop until the internal write finishes
// - page writes of up to 8 bytes continue with data instead of stop
// - up to seven more data bytes, each acked, ended by a stop
// - after each data byte only the lowest three address bits increment
// - past the page boundary the address wraps to the same page start
// - polling with start and address gets an ack only after the write ends
// - write protect high blocks array writes, reads still allowed
// - data sampled on rising clock edges, output changed after falling edges
// - 1-kbit uses 7-bit address over 16 pages, 2-kbit 8-bit over 32 pages
package eeprom_pkg;
  // word and page geometry
  localparam int WORD_W = 8;
  localparam int ADDR_W = 8;
  localparam int PAGE_BYTES = 8;
  localparam int PAGE_OFS_W = 3;
  localparam int MEM_BYTES = 256;
  localparam logic [ADDR_W-1:0] ADDR_MASK_2K = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_MASK_1K = 8'h7F;
  // device address word fields
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_SEL_MSB = 3;
  localparam int DEV_SEL_LSB = 1;
  localparam int DEV_DIR_BIT = 0;
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_SERIAL = 4'hB;
  // bit counter marks
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 4'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_ACK = 4'h8;
  // internal write time, longest time rounds down
  localparam int WR_TIME_MS = 5;
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int WR_CYCLES_DEF = WR_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int WR_CNT_W = 18;
  // protocol states, gray along idle-address-word-data-write
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_WORDADDR = 3'h3,
    ST_DATA = 3'h2,
    ST_NVWRITE = 3'h6,
    ST_IGNORE = 3'h4
  } state_t;
endpackage

// >>> shared/bit_link_if.sv
`timescale 1ns/10ps
// one sampled bit and its event toggle, from the serial clock domain
interface bit_link_if;
  logic bit_val;
  logic bit_tgl;
  modport capture (output bit_val, output bit_tgl);
  modport core (input bit_val, input bit_tgl);
endinterface

// >>> hdl/serial_bit_capture.sv
`timescale 1ns/10ps
module serial_bit_capture
  import eeprom_pkg::*;
(
  input wire logic scl_clk_i,
  input wire logic resetn_i,
  input wire logic sda_i,
  bit_link_if.capture link
);
  logic bit_val_reg;
  logic bit_tgl_reg;

  // sample data on each rising serial clock, flip the event toggle
  // async clear: the serial clock may stand still during reset
  always_ff @(posedge scl_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bit_val_reg <= 1'b0;
      bit_tgl_reg <= 1'b0;
    end
    else
    begin
      bit_val_reg <= sda_i;
      bit_tgl_reg <= ~bit_tgl_reg;
    end
  end

  assign link.bit_val = bit_val_reg;
  assign link.bit_tgl = bit_tgl_reg;
endmodule

// >>> hdl/twowire_eeprom_slave_write_path.sv
`timescale 1ns/10ps
module twowire_eeprom_slave_write_path
  import eeprom_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYCLES_DEF,
  parameter bit VARIANT_1K = 1'b0
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic select_pin_high_i,
  input wire logic select_pin_mid_i,
  input wire logic select_pin_low_i,
  input wire logic write_protect_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [WORD_W-1:0] rd_data_o,
  output logic standby_o,
  output logic busy_o
);
  bit_link_if link_bus ();

  // serial clock domain front end
  serial_bit_capture u_capture (
    .scl_clk_i (scl_i),
    .resetn_i (resetn_i),
    .sda_i (sda_i),
    .link (link_bus.capture)
  );

  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic tgl_s1_reg, tgl_s2_reg, tgl_seen_reg;
  logic bitv_s1_reg, bitv_s2_reg;
  logic [2:0] sel_s1_reg, sel_s2_reg;
  logic wp_s1_reg, wp_s2_reg;
  logic ev_d_reg;
  state_t state_reg, state_next;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [WORD_W-2:0] shift_reg;
  logic ack_pend_reg;
  logic sn_sel_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [WORD_W-1:0] page_buf_reg [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask_reg;
  logic [WR_CNT_W-1:0] wr_cnt_reg;
  logic [WORD_W-1:0] mem_reg [MEM_BYTES];
  logic sda_o_reg, sda_oe_reg, standby_reg, busy_reg;
  logic [WORD_W-1:0] rd_data_reg;

  // pin and crossing synchronisers, two flops before any logic
  always_ff @(posedge clk_i)
  begin
    scl_s1_reg <= scl_i;
    scl_s2_reg <= scl_s1_reg;
    scl_s3_reg <= scl_s2_reg;
    sda_s1_reg <= sda_i;
    sda_s2_reg <= sda_s1_reg;
    sda_s3_reg <= sda_s2_reg;
    tgl_s1_reg <= link_bus.bit_tgl;
    tgl_s2_reg <= tgl_s1_reg;
    bitv_s1_reg <= link_bus.bit_val;
    bitv_s2_reg <= bitv_s1_reg;
    sel_s1_reg <= {select_pin_high_i, select_pin_mid_i, select_pin_low_i};
    sel_s2_reg <= sel_s1_reg;
    wp_s1_reg <= write_protect_i;
    wp_s2_reg <= wp_s1_reg;
  end

  // line condition decode
  wire scl_high = scl_s2_reg & scl_s3_reg;
  wire scl_fall = scl_s3_reg & ~scl_s2_reg;
  wire start_det = scl_high & sda_s3_reg & ~sda_s2_reg;
  wire stop_det = scl_high & ~sda_s3_reg & sda_s2_reg;
  wire bit_ev = tgl_s2_reg ^ tgl_seen_reg;

  // byte assembly decode
  wire byte_done = ev_d_reg & (bit_cnt_reg == BIT_LAST);
  wire [WORD_W-1:0] rx_byte = {shift_reg, bitv_s2_reg};
  wire [3:0] dev_type = rx_byte[DEV_TYPE_MSB:DEV_TYPE_LSB];
  wire sel_match = rx_byte[DEV_SEL_MSB:DEV_SEL_LSB] == sel_s2_reg;
  wire type_ok = (dev_type == TYPE_ARRAY) | (dev_type == TYPE_SERIAL);
  wire dir_read = rx_byte[DEV_DIR_BIT];
  wire dev_done = byte_done & (state_reg == ST_DEVADDR);
  wire dev_hit = dev_done & type_ok & sel_match;
  wire word_done = byte_done & (state_reg == ST_WORDADDR);
  wire data_done = byte_done & (state_reg == ST_DATA);
  wire store_en = data_done & ~sn_sel_reg & ~wp_s2_reg;
  wire ack_req = dev_hit | word_done | data_done;
  wire [ADDR_W-1:0] addr_mask = VARIANT_1K ? ADDR_MASK_1K : ADDR_MASK_2K;
  wire [PAGE_OFS_W-1:0] page_ofs = ptr_reg[PAGE_OFS_W-1:0];
  wire wr_last = wr_cnt_reg == WR_CNT_W'(WR_CYCLES - 1);

  // next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_NVWRITE:
      begin
        // inputs ignored until the timed write ends
        if (wr_last)
        begin
          state_next = ST_IDLE;
        end
      end
      ST_DEVADDR:
      begin
        if (stop_det)
        begin
          state_next = ST_IDLE;
        end
        else if (start_det)
        begin
          state_next = ST_DEVADDR;
        end
        else if (dev_done)
        begin
          if (!dev_hit)
          begin
            state_next = ST_IDLE;
          end
          else if (dir_read)
          begin
            state_next = ST_IGNORE;
          end
          else
          begin
            state_next = ST_WORDADDR;
          end
        end
      end
      ST_WORDADDR:
      begin
        if (stop_det)
        begin
          state_next = ST_IDLE;
        end
        else if (start_det)
        begin
          state_next = ST_DEVADDR;
        end
        else if (word_done)
        begin
          state_next = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (stop_det)
        begin
          state_next = (|page_mask_reg) ? ST_NVWRITE : ST_IDLE;
        end
        else if (start_det)
        begin
          state_next = ST_DEVADDR;
        end
      end
      ST_IDLE, ST_IGNORE:
      begin
        if (stop_det)
        begin
          state_next = ST_IDLE;
        end
        else if (start_det)
        begin
          state_next = ST_DEVADDR;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // state register, reset to standby
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // bit event tracking; sync reset loads the current toggle level
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      tgl_seen_reg <= tgl_s2_reg;
      ev_d_reg <= 1'b0;
    end
    else
    begin
      tgl_seen_reg <= tgl_s2_reg;
      ev_d_reg <= bit_ev;
    end
  end

  // bit counter and shifter, cleared by any start
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || start_det)
    begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
    end
    else if (ev_d_reg)
    begin
      bit_cnt_reg <= (bit_cnt_reg == BIT_ACK) ? '0 : bit_cnt_reg + 1'b1;
      shift_reg <= {shift_reg[WORD_W-3:0], bitv_s2_reg};
    end
  end

  // acknowledge driver: low after the falling edge ending bit 8, release after the ninth
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || start_det || stop_det || state_reg == ST_NVWRITE)
    begin
      ack_pend_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (ack_req)
    begin
      ack_pend_reg <= 1'b1;
    end
    else if (scl_fall && ack_pend_reg)
    begin
      ack_pend_reg <= 1'b0;
      sda_oe_reg <= 1'b1;
    end
    else if (scl_fall && sda_oe_reg && bit_cnt_reg == '0)
    begin
      sda_oe_reg <= 1'b0;
    end
  end

  // open-drain data level is always low
  always_ff @(posedge clk_i)
  begin
    sda_o_reg <= 1'b0;
  end

  // area select and word pointer
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      sn_sel_reg <= 1'b0;
      ptr_reg <= '0;
    end
    else if (dev_hit)
    begin
      sn_sel_reg <= dev_type == TYPE_SERIAL;
    end
    else if (word_done)
    begin
      ptr_reg <= rx_byte & addr_mask;
    end
    else if (data_done)
    begin
      ptr_reg <= {ptr_reg[ADDR_W-1:PAGE_OFS_W], page_ofs + 1'b1};
    end
  end

  // page buffer, later bytes overwrite earlier ones at the same offset
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || word_done || (state_reg == ST_NVWRITE && wr_last))
    begin
      page_mask_reg <= '0;
    end
    else if (store_en)
    begin
      page_buf_reg[page_ofs] <= rx_byte;
      page_mask_reg[page_ofs] <= 1'b1;
    end
  end

  // write cycle timer, runs from the stop
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || state_reg != ST_NVWRITE)
    begin
      wr_cnt_reg <= '0;
    end
    else
    begin
      wr_cnt_reg <= wr_cnt_reg + 1'b1;
    end
  end

  // commit the loaded page bytes at the end of the write cycle
  always_ff @(posedge clk_i)
  begin
    if (state_reg == ST_NVWRITE && wr_last)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (page_mask_reg[i])
        begin
          mem_reg[{ptr_reg[ADDR_W-1:PAGE_OFS_W], PAGE_OFS_W'(i)}] <= page_buf_reg[i];
        end
      end
    end
  end

  // status and array read port
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      standby_reg <= 1'b1;
      busy_reg <= 1'b0;
      rd_data_reg <= '0;
    end
    else
    begin
      standby_reg <= state_next == ST_IDLE;
      busy_reg <= state_next == ST_NVWRITE;
      rd_data_reg <= mem_reg[rd_addr_i & addr_mask];
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe_o = sda_oe_reg;
  assign standby_o = standby_reg;
  assign busy_o = busy_reg;
  assign rd_data_o = rd_data_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_drive_low_only: assert property (
    sda_oe_o |-> !sda_o)
    else $error("data line driven high");

  a_silent_busy: assert property (
    (state_reg == ST_NVWRITE) [*2] |-> !sda_oe_o)
    else $error("response during write cycle");

  a_start_restart: assert property (
    start_det && state_reg != ST_NVWRITE |=> state_reg == ST_DEVADDR && bit_cnt_reg == '0)
    else $error("start did not restart address phase");

  a_stop_standby: assert property (
    stop_det && state_reg != ST_DATA && state_reg != ST_NVWRITE |=> state_reg == ST_IDLE
    ##1 standby_o)
    else $error("stop did not reach standby");

  a_write_begins: assert property (
    stop_det && state_reg == ST_DATA && |page_mask_reg |=> state_reg == ST_NVWRITE
    && wr_cnt_reg == '0)
    else $error("write cycle not started at stop");

  a_timer_bound: assert property (
    state_reg == ST_NVWRITE |-> wr_cnt_reg < WR_CNT_W'(WR_CYCLES))
    else $error("write cycle overran");

  a_page_wrap: assert property (
    data_done |=> ptr_reg[ADDR_W-1:PAGE_OFS_W] == $past(ptr_reg[ADDR_W-1:PAGE_OFS_W])
    && ptr_reg[PAGE_OFS_W-1:0] == PAGE_OFS_W'($past(ptr_reg[PAGE_OFS_W-1:0]) + 1'b1))
    else $error("pointer left the page");

  a_protect_block: assert property (
    wp_s2_reg && state_reg == ST_DATA |=> $stable(page_mask_reg) || page_mask_reg == '0)
    else $error("byte stored while protected");

  a_serial_locked: assert property (
    sn_sel_reg && data_done |=> $stable(page_mask_reg))
    else $error("serial block write accepted");

  a_mismatch_quiet: assert property (
    dev_done && !sel_match |=> state_reg == ST_IDLE && !ack_pend_reg ##1 !sda_oe_o)
    else $error("acked a foreign address");

  a_ack_on_fall: assert property (
    scl_fall && ack_pend_reg && !start_det && !stop_det && state_reg != ST_NVWRITE
    |=> sda_oe_o)
    else $error("acknowledge not driven");
endmodule

// >>> testbench/twowire_master_model.sv
`timescale 1ns/10ps
// bus master: open-drain data, serial clock runs only inside frames
module twowire_master_model
(
  input wire logic tick_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  localparam int HALF = 7;
  // idle bus, both lines released high
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // half a serial clock period
  task automatic hold();
    repeat (HALF) @(posedge tick_i);
  endtask
  // one bit, data moved only while the clock is low
  task automatic clock_bit(input logic b, output logic seen);
    sda_low_o <= !b;
    hold();
    scl_o <= 1'b1;
    hold();
    seen = sda_i;
    scl_o <= 1'b0;
    @(posedge tick_i);
  endtask
  // falling data with clock high, also usable as a repeated start
  task automatic start_cond();
    sda_low_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_low_o <= 1'b1;
    hold();
    scl_o <= 1'b0;
    @(posedge tick_i);
  endtask
  // rising data with clock high
  task automatic stop_cond();
    sda_low_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_low_o <= 1'b0;
    hold();
  endtask
  // eight bits msb first, ninth clock with data released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i], seen);
    clock_bit(1'b1, seen);
    ack = !seen;
  endtask
  // bus recovery: start, nine clocks, start, stop
  task automatic recover();
    logic seen;
    start_cond();
    repeat (9) clock_bit(1'b1, seen);
    start_cond();
    stop_cond();
  endtask
endmodule

// >>> testbench/twowire_eeprom_slave_write_path_tb.sv
`timescale 1ns/10ps
module twowire_eeprom_slave_write_path_tb;
  import eeprom_pkg::*;
  localparam int WR_N = 200;
  localparam logic [2:0] SEL = 3'h5;
  logic clk_i = 1'b0;
  logic tick = 1'b0;
  logic resetn_i = 1'b0;
  logic wp = 1'b0;
  logic [2:0] sel = SEL;
  logic [7:0] rd_addr = 8'h00;
  logic [7:0] rd_data;
  logic scl, m_low, sda_w, sda_o, sda_oe_o, standby, busy;
  logic sda_o_1k, sda_oe_1k, standby_1k, busy_1k;
  logic [7:0] rd_data_1k;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // system clock, and a link tick of unrelated phase
  always #10 clk_i = !clk_i;
  initial #3.3 forever #7.5 tick = !tick;
  // open-drain data wire with pull-up
  assign sda_w = !(m_low || (sda_oe_o && !sda_o) || (sda_oe_1k && !sda_o_1k));
  twowire_eeprom_slave_write_path #(.WR_CYCLES(WR_N)) twowire_eeprom_slave_write_path_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .select_pin_high_i(sel[2]), .select_pin_mid_i(sel[1]),
    .select_pin_low_i(sel[0]), .write_protect_i(wp), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .standby_o(standby), .busy_o(busy));
  // narrow-address variant on the same bus and select pins, acks alongside
  twowire_eeprom_slave_write_path #(.WR_CYCLES(WR_N), .VARIANT_1K(1'b1))
    twowire_eeprom_slave_write_path_1k_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o_1k),
    .sda_oe_o(sda_oe_1k), .select_pin_high_i(sel[2]), .select_pin_mid_i(sel[1]),
    .select_pin_low_i(sel[0]), .write_protect_i(wp), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data_1k), .standby_o(standby_1k), .busy_o(busy_1k));
  twowire_master_model twowire_master_model_inst (
    .tick_i(tick), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      final_report();
    end
  end
  // device only ever pulls the line low
  always @(posedge clk_i)
  begin
    if (sda_oe_o === 1'b1)
      chk("sda_o", sda_o, 0);
    if (sda_oe_1k === 1'b1)
      chk("sda_o 1k", sda_o_1k, 0);
  end
  task automatic dev_addr(input logic [3:0] k, input logic [2:0] s, input logic rd,
                          output logic a);
    twowire_master_model_inst.start_cond();
    twowire_master_model_inst.send_byte({k, s, rd}, a);
  endtask
  task automatic write_seq(input logic [3:0] k, input logic [7:0] wa, input int n,
                           input logic [7:0] d0);
    logic a;
    dev_addr(k, SEL, 1'b0, a);
    chk("addr ack", a, 1);
    twowire_master_model_inst.send_byte(wa, a);
    chk("word ack", a, 1);
    for (int i = 0; i < n; i++)
    begin
      twowire_master_model_inst.send_byte(d0 + 8'(i), a);
      chk("data ack", a, 1);
    end
    twowire_master_model_inst.stop_cond();
  endtask
  task automatic wait_idle(output int t);
    t = 0;
    repeat (2) @(posedge clk_i);
    while (busy !== 1'b0 && t < 1000)
    begin
      @(posedge clk_i);
      t++;
    end
    #1 chk("standby", standby, 1);
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #1 rd_addr = a;
    repeat (2) @(posedge clk_i);
    #1 chk("rd_data", rd_data, exp);
  endtask
  task automatic settle(input logic [2:0] s, input logic w);
    @(posedge clk_i);
    #1 sel = s;
    wp = w;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic t_byte_write();
    logic a;
    int t0, t;
    write_seq(TYPE_ARRAY, 8'h12, 1, 8'h5A);
    t0 = cyc;
    repeat (2) @(posedge clk_i);
    #1 chk("busy", busy, 1);
    chk("standby", standby, 0);
    dev_addr(TYPE_ARRAY, SEL, 1'b0, a);
    chk("poll busy", a, 0);
    twowire_master_model_inst.stop_cond();
    wait_idle(t);
    t = cyc - t0;
    chk("write time", (t >= WR_N - 10 && t <= WR_N + 2), 1);
    dev_addr(TYPE_ARRAY, SEL, 1'b0, a);
    chk("poll done", a, 1);
    twowire_master_model_inst.stop_cond();
    wait_idle(t);
    peek(8'h12, 8'h5A);
  endtask
  task automatic t_page_wrap();
    int t, i;
    write_seq(TYPE_ARRAY, 8'h2E, 10, 8'hD0);
    wait_idle(t);
    for (int o = 0; o < 8; o++)
    begin
      i = (o - 6) & 7;
      if (i < 2)
        i += 8;
      peek(8'h28 + 8'(o), 8'hD0 + 8'(i));
    end
  endtask
  task automatic t_select();
    logic a;
    for (int s = 0; s < 8; s++)
    begin
      dev_addr(TYPE_ARRAY, 3'(s), 1'b0, a);
      chk("select ack", a, (s == SEL));
      twowire_master_model_inst.stop_cond();
    end
    dev_addr(4'h9, SEL, 1'b0, a);
    chk("type ack", a, 0);
    twowire_master_model_inst.stop_cond();
    settle(3'h2, 1'b0);
    dev_addr(TYPE_ARRAY, 3'h2, 1'b0, a);
    chk("pin ack", a, 1);
    twowire_master_model_inst.stop_cond();
    settle(SEL, 1'b0);
    chk("standby", standby, 1);
  endtask
  task automatic t_protect_serial();
    int t;
    write_seq(TYPE_ARRAY, 8'h40, 1, 8'h11);
    wait_idle(t);
    settle(SEL, 1'b1);
    write_seq(TYPE_ARRAY, 8'h40, 1, 8'h22);
    repeat (4) @(posedge clk_i);
    #1 chk("wp busy", busy, 0);
    settle(SEL, 1'b0);
    peek(8'h40, 8'h11);
    write_seq(TYPE_SERIAL, 8'h80, 1, 8'h33);
    repeat (4) @(posedge clk_i);
    #1 chk("serial busy", busy, 0);
  endtask
  task automatic t_read_restart();
    logic a;
    int t;
    dev_addr(TYPE_ARRAY, SEL, 1'b1, a);
    chk("read ack", a, 1);
    twowire_master_model_inst.stop_cond();
    repeat (8) @(posedge clk_i);
    #1 chk("standby", standby, 1);
    dev_addr(TYPE_ARRAY, SEL, 1'b0, a);
    twowire_master_model_inst.send_byte(8'h12, a);
    repeat (4) twowire_master_model_inst.clock_bit(1'b0, a);
    write_seq(TYPE_ARRAY, 8'h13, 1, 8'h77);
    wait_idle(t);
    peek(8'h12, 8'h5A);
    peek(8'h13, 8'h77);
    twowire_master_model_inst.recover();
    dev_addr(TYPE_ARRAY, SEL, 1'b0, a);
    chk("after recovery", a, 1);
    twowire_master_model_inst.stop_cond();
  endtask
  // word address with bit 7 set: the narrow variant drops it on write and read
  task automatic t_small_variant();
    logic a;
    dev_addr(TYPE_ARRAY, SEL, 1'b0, a);
    chk("1k addr ack", a, 1);
    twowire_master_model_inst.send_byte(8'hC5, a);
    twowire_master_model_inst.send_byte(8'h6E, a);
    chk("1k data ack", a, 1);
    twowire_master_model_inst.stop_cond();
    repeat (2) @(posedge clk_i);
    #1 chk("1k busy", busy_1k, 1);
    repeat (WR_N + 8) @(posedge clk_i);
    #1 chk("1k idle", busy_1k, 0);
    chk("1k standby", standby_1k, 1);
    rd_addr = 8'hC5;
    repeat (2) @(posedge clk_i);
    #1 chk("2k wide addr", rd_data, 8'h6E);
    chk("1k read mask", rd_data_1k, 8'h6E);
    rd_addr = 8'h45;
    repeat (2) @(posedge clk_i);
    #1 chk("1k write mask", rd_data_1k, 8'h6E);
  endtask
  // reset, then the scenarios
  initial
  begin
    repeat (16) @(posedge clk_i);
    #1 chk("standby", standby, 1);
    chk("busy", busy, 0);
    chk("sda_oe", sda_oe_o, 0);
    chk("sda_oe 1k", sda_oe_1k, 0);
    resetn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    t_byte_write();
    t_page_wrap();
    t_select();
    t_protect_serial();
    t_read_restart();
    t_small_variant();
    final_report();
  end
endmodule
